// ==== ih_pkg.sv ====
// ih_pkg: constants shared by the interrupt hierarchy block.
// Assumes a 25 MHz system clock and a 16-bit Avalon-MM register port.
// What this block does
// - All sources share one vector, equal priority, one serviced at a time.
// - Hardware sources reach the CPU only with local, module and global enables; software flags need module and global.
// - Global enable resets to 0; software sets it before interrupts.
// - All module and system mask bits live in one mask register.
// - Flags set on their condition even while disabled anywhere.
// - Pending register has one bit per module plus one system bit.
// - Ports 0-2 pins and timer 1 form pending bit 0, mask bit 0.
// - Port 6 pins, supply monitor, two-wire master form bit 1.
// - Two-wire master has eight flag and enable pairs.
// - Fourteen two-wire slave sources form pending bit 2, mask bit 2.
// - ADC, temperature, sample-holds, three-wire, SPI slave form bit 4.
// - 16 low, 16 high comparator flags and SPI master form bit 5.
// - Each source id bit is the OR of its flags ANDed with enables.
// - Source id registers are 16-bit, read-only, reset 0, reserved read 0.
// - Module 1 id: master bit 8, supply monitor bit 7, port 6 bits 6:0.
// - Module 4 id: SPI slave bit 2, three-wire bit 1, ADC bit 0.
// - Module 5 id: fast comparator bit 1, SPI master bit 0.
// - Vector register takes any address and resets to 0000h.
// - Requests sampled each edge, serviced a cycle later, not in a window.
// - Service cancels fetch, pushes return, sets in-service, loads vector.
// - Return pops, clears in-service, is not interrupted; two-cycle gap.
// - Outside stop mode pin requests need three stable cycles.
package ih_pkg;
  // register word indices on the bus
  localparam logic [3:0] IH_ADDR_CTRL = 4'h0;
  localparam logic [3:0] IH_ADDR_MASK = 4'h1;
  localparam logic [3:0] IH_ADDR_PEND = 4'h2;
  localparam logic [3:0] IH_ADDR_VECT = 4'h3;
  localparam logic [3:0] IH_ADDR_ID1  = 4'h4;
  localparam logic [3:0] IH_ADDR_ID4  = 4'h5;
  localparam logic [3:0] IH_ADDR_ID5  = 4'h6;
  localparam logic [3:0] IH_ADDR_SWF  = 4'h7;
  // control register fields
  localparam int IH_CTRL_GIE = 0;
  localparam int IH_CTRL_INSVC = 1;
  // system bit position in mask and pending registers
  localparam int IH_SYS_BIT = 15;
  localparam int IH_NMOD    = 6;
  // module 1 id fields
  localparam int IH_ID1_SUPMON = 7;
  localparam int IH_ID1_TWM    = 8;
  // module 4 and 5 id fields
  localparam int IH_ID4_ADC = 0;
  localparam int IH_ID4_TW3 = 1;
  localparam int IH_ID4_SPS = 2;
  localparam int IH_ID5_SPM = 0;
  localparam int IH_ID5_CMP = 1;
  // reset values
  localparam logic [15:0] IH_RST_ZERO = 16'h0000;
  localparam logic [15:0] IH_RST_VECT = 16'h0000;
  // glitch filter length in system clocks
  localparam int IH_FILT_TAPS = 3;
endpackage

// ==== ih_glitch_filter.sv ====
// ih_glitch_filter: synchroniser plus stable-sample filter for pin requests.
// Assumes asynchronous inputs and a single system clock.
`timescale 1ns/100ps
`default_nettype none
module ih_glitch_filter #(
  parameter int W    = 1,
  parameter int TAPS = 3
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // control
  input  wire logic         stop_mode,
  // data
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] filt_r
);
  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [W-1:0] hist_r [TAPS];
  logic [W-1:0] all1;
  logic [W-1:0] all0;

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  // history of synchronised samples
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < TAPS; i++) hist_r[i] <= '0;
    end else begin
      hist_r[0] <= sync2_r;
      for (int i = 1; i < TAPS; i++) hist_r[i] <= hist_r[i-1];
    end
  end

  // a level counts only once it held for all taps
  always_comb begin
    all1 = '1;
    all0 = '1;
    for (int i = 0; i < TAPS; i++) begin
      all1 = all1 & hist_r[i];
      all0 = all0 & ~hist_r[i];
    end
  end

  // in stop mode the filter clock is not trusted, so pass through
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) filt_r <= '0;
    else if (stop_mode) filt_r <= sync2_r;
    else filt_r <= (filt_r | all1) & ~all0;
  end
endmodule // ih_glitch_filter
`default_nettype wire

// ==== ih_top.sv ====
// ih_top: interrupt aggregation, masking and CPU request sequencing.
// Assumes peripheral flags and enables are synchronous except pin requests,
// and that the CPU acts on irq_take_r and signals returns with rfi.
`timescale 1ns/100ps
`default_nettype none
module ih_top
  import ih_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [15:0] avs_writedata,
  input  wire logic [1:0]  avs_byteenable,
  output logic      [15:0] avs_readdata,
  output logic             avs_waitrequest,
  // module 0 sources
  input  wire logic [23:0] pin012_flag,
  input  wire logic [23:0] pin012_en,
  input  wire logic        tmr1_flag,
  input  wire logic        tmr1_en,
  // module 1 sources
  input  wire logic [6:0]  port6_flag,
  input  wire logic [6:0]  port6_en,
  input  wire logic        supmon_flag,
  input  wire logic        supmon_en,
  input  wire logic [7:0]  twm_flag,
  input  wire logic [7:0]  twm_en,
  // module 2 sources
  input  wire logic [13:0] tws_flag,
  input  wire logic [13:0] tws_en,
  // module 3 sources
  input  wire logic        tmr2_flag,
  input  wire logic        tmr2_en,
  // module 4 sources
  input  wire logic [3:0]  adc_flag,
  input  wire logic [3:0]  adc_en,
  input  wire logic        tw3_flag,
  input  wire logic        tw3_en,
  input  wire logic [2:0]  spis_flag,
  input  wire logic        spis_en,
  // module 5 sources
  input  wire logic [15:0] cmp_lo_flag,
  input  wire logic [15:0] cmp_lo_en,
  input  wire logic [15:0] cmp_hi_flag,
  input  wire logic [15:0] cmp_hi_en,
  input  wire logic [3:0]  spim_flag,
  input  wire logic        spim_en,
  // system source
  input  wire logic        wdt_flag,
  input  wire logic        wdt_en,
  // cpu side
  input  wire logic        stop_mode,
  input  wire logic        exc_window,
  input  wire logic        rfi,
  output logic             irq_req_r,
  output logic             irq_take_r,
  output logic      [15:0] handler_vector,
  output logic             in_service_bit
);
  import ih_pkg::*;

  typedef enum logic [0:0] {IH_IDLE, IH_ACK} ih_state_e;

  ih_state_e      state_r;
  ih_state_e      state_nxt;
  logic [15:0]    module_mask_reg;
  logic           global_irq_enable;
  logic [3:0]     swf_r;
  logic [15:0]    module1_source_id;
  logic [15:0]    module4_source_id;
  logic [15:0]    module5_source_id;
  logic [15:0]    module_pending_reg;
  logic [23:0]    pin012_filt;
  logic [6:0]     port6_filt;
  logic [15:0]    id1_nxt;
  logic [15:0]    id4_nxt;
  logic [15:0]    id5_nxt;
  logic [15:0]    pend_nxt;
  logic           any_masked;
  logic           acc;
  logic           wr_hit;
  logic [15:0]    wmask;
  logic [15:0]    rd_nxt;

  // pin requests are asynchronous and must pass the glitch filter
  ih_glitch_filter #(
    .W    (24),
    .TAPS (IH_FILT_TAPS)
  ) u_filt012 (
    .clock     (clock),
    .rst_n     (rst_n),
    .stop_mode (stop_mode),
    .raw       (pin012_flag),
    .filt_r    (pin012_filt)
  );

  ih_glitch_filter #(
    .W    (7),
    .TAPS (IH_FILT_TAPS)
  ) u_filt6 (
    .clock     (clock),
    .rst_n     (rst_n),
    .stop_mode (stop_mode),
    .raw       (port6_flag),
    .filt_r    (port6_filt)
  );

  // bus handshake: one wait cycle, answer on the next edge
  assign acc    = (avs_read | avs_write) & avs_waitrequest;
  assign wr_hit = avs_write & ~avs_waitrequest;
  assign wmask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) avs_waitrequest <= 1'b1;
    else if (acc) avs_waitrequest <= 1'b0;
    else avs_waitrequest <= 1'b1;
  end

  // per-function source id bits, each an OR of flag AND enable
  always_comb begin
    id1_nxt = IH_RST_ZERO;
    id1_nxt[6:0] = port6_filt & port6_en;
    id1_nxt[IH_ID1_SUPMON] = supmon_flag & supmon_en;
    id1_nxt[IH_ID1_TWM] = |(twm_flag & twm_en);
    id4_nxt = IH_RST_ZERO;
    id4_nxt[IH_ID4_ADC] = |(adc_flag & adc_en);
    id4_nxt[IH_ID4_TW3] = tw3_flag & tw3_en;
    id4_nxt[IH_ID4_SPS] = |spis_flag & spis_en;
    id5_nxt = IH_RST_ZERO;
    id5_nxt[IH_ID5_SPM] = |spim_flag & spim_en;
    id5_nxt[IH_ID5_CMP] = |(cmp_lo_flag & cmp_lo_en) |
                          |(cmp_hi_flag & cmp_hi_en);
  end

  // id registers are read-only, reserved bits stay zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      module1_source_id <= IH_RST_ZERO;
      module4_source_id <= IH_RST_ZERO;
      module5_source_id <= IH_RST_ZERO;
    end else begin
      module1_source_id <= id1_nxt;
      module4_source_id <= id4_nxt;
      module5_source_id <= id5_nxt;
    end
  end

  // module pending bits, system bit at the top
  always_comb begin
    pend_nxt = IH_RST_ZERO;
    pend_nxt[0] = |(pin012_filt & pin012_en) |
                  (tmr1_flag & tmr1_en);
    pend_nxt[1] = |id1_nxt;
    pend_nxt[2] = |(tws_flag & tws_en);
    pend_nxt[3] = |swf_r | (tmr2_flag & tmr2_en);
    pend_nxt[4] = |id4_nxt;
    pend_nxt[5] = |id5_nxt;
    pend_nxt[IH_SYS_BIT] = wdt_flag & wdt_en;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) module_pending_reg <= IH_RST_ZERO;
    else module_pending_reg <= pend_nxt;
  end

  // global enable lives in the control word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= 1'b0;
    end else if (wr_hit && avs_address == IH_ADDR_CTRL &&
                 avs_byteenable[0]) begin
      global_irq_enable <= avs_writedata[IH_CTRL_GIE];
    end
  end

  // one mask word covers every module plus system, so one write
  // can mask or unmask several modules at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      module_mask_reg <= IH_RST_ZERO;
    end else if (wr_hit && avs_address == IH_ADDR_MASK) begin
      module_mask_reg <= (module_mask_reg & ~wmask) |
                         (avs_writedata & wmask);
    end
  end

  // vector takes any address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      handler_vector <= IH_RST_VECT;
    end else if (wr_hit && avs_address == IH_ADDR_VECT) begin
      handler_vector <= (handler_vector & ~wmask) |
                        (avs_writedata & wmask);
    end
  end

  // software flags are set regardless of any enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      swf_r <= 4'h0;
    end else if (wr_hit && avs_address == IH_ADDR_SWF &&
                 avs_byteenable[0]) begin
      swf_r <= avs_writedata[3:0];
    end
  end

  // in-service bit: entry sets, return or software clears;
  // set wins so an entry in the clearing cycle is not lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_service_bit <= 1'b0;
    end else if (state_r == IH_ACK) begin
      in_service_bit <= 1'b1;
    end else if (rfi) begin
      in_service_bit <= 1'b0;
    end else if (wr_hit && avs_address == IH_ADDR_CTRL &&
                 avs_byteenable[0]) begin
      in_service_bit <= avs_writedata[IH_CTRL_INSVC];
    end
  end

  // any pending module whose mask bit is on
  assign any_masked = |(module_pending_reg & module_mask_reg);

  // request; a return cycle never raises one, giving the two-cycle gap.
  // a flag left set by the handler simply requests again
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq_req_r <= 1'b0;
    else irq_req_r <= global_irq_enable & ~in_service_bit &
                      ~rfi & any_masked & (state_r == IH_IDLE) &
                      ~irq_take_r;
  end

  // sequencer: sample, one stall cycle, then take
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IH_IDLE: begin
        if (irq_req_r && !exc_window && !rfi) state_nxt = IH_ACK;
      end
      IH_ACK: begin
        state_nxt = IH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) state_r <= IH_IDLE;
    else state_r <= state_nxt;
  end

  // take pulse tells the cpu to cancel fetch, push and jump to vector
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq_take_r <= 1'b0;
    else irq_take_r <= (state_r == IH_ACK);
  end

  // read mux; unmapped words return zero
  always_comb begin
    rd_nxt = IH_RST_ZERO;
    unique case (avs_address)
      IH_ADDR_CTRL: begin
        rd_nxt[IH_CTRL_GIE] = global_irq_enable;
        rd_nxt[IH_CTRL_INSVC] = in_service_bit;
      end
      IH_ADDR_MASK: rd_nxt = module_mask_reg;
      IH_ADDR_PEND: rd_nxt = module_pending_reg;
      IH_ADDR_VECT: rd_nxt = handler_vector;
      IH_ADDR_ID1:  rd_nxt = module1_source_id;
      IH_ADDR_ID4:  rd_nxt = module4_source_id;
      IH_ADDR_ID5:  rd_nxt = module5_source_id;
      IH_ADDR_SWF:  rd_nxt[3:0] = swf_r;
      default:      rd_nxt = IH_RST_ZERO;
    endcase
  end

  // data is latched with the cycle that drops waitrequest
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) avs_readdata <= IH_RST_ZERO;
    else if (acc && avs_read) avs_readdata <= rd_nxt;
  end
endmodule // ih_top
`default_nettype wire

// ==== ih_top_sva.sv ====
// ih_top_sva: port-level checks of the interrupt hierarchy.
// Assumes it is bound into ih_top; bus and cpu side share one clock.
`timescale 1ns/100ps
`default_nettype none
module ih_top_sva
  import ih_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [15:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // cpu side
  input wire logic        exc_window,
  input wire logic        rfi,
  input wire logic        irq_req_r,
  input wire logic        irq_take_r,
  input wire logic [15:0] handler_vector,
  input wire logic        in_service_bit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a taken access is answered on the next cycle, for one cycle only
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer");
  // reserved id bits read zero
  AST_ID1_RSVD: assert property (avs_read && !avs_waitrequest &&
    avs_address == IH_ADDR_ID1 |-> avs_readdata[15:9] == 7'h00)
    else $error("id1 reserved bits");
  AST_ID4_RSVD: assert property (avs_read && !avs_waitrequest &&
    avs_address == IH_ADDR_ID4 |-> avs_readdata[15:3] == 13'h0000)
    else $error("id4 reserved bits");
  AST_ID5_RSVD: assert property (avs_read && !avs_waitrequest &&
    avs_address == IH_ADDR_ID5 |-> avs_readdata[15:2] == 14'h0000)
    else $error("id5 reserved bits");
  // entry is a single pulse and marks the block busy
  AST_TAKE_PULSE: assert property (irq_take_r |=> !irq_take_r)
    else $error("take longer than one cycle");
  AST_TAKE_INS: assert property (irq_take_r |-> in_service_bit)
    else $error("in service not set at entry");
  AST_NO_NEST: assert property (in_service_bit && $past(in_service_bit)
    |-> !irq_req_r) else $error("request while in service");
  // one stall cycle, plus one per non-interruptible cycle
  AST_REQ_TAKE: assert property (irq_req_r && !exc_window && !rfi
    |-> ##[1:3] irq_take_r) else $error("request not serviced");
  AST_TAKE_CAUSE: assert property (irq_take_r
    |-> $past(irq_req_r, 2) || $past(irq_req_r, 3))
    else $error("entry without request");
  AST_RFI_GAP: assert property (rfi |=> !irq_take_r ##1 !irq_take_r)
    else $error("entry too soon after return");
  // vector moves only on a completed bus write to it
  AST_VECT_WRITE: assert property (!$stable(handler_vector) |->
    $past(avs_write && !avs_waitrequest && avs_address == IH_ADDR_VECT))
    else $error("vector changed without write");
endmodule // ih_top_sva
bind ih_top ih_top_sva ih_top_sva_i (.*);
`default_nettype wire

// ==== ih_cpu_model.sv ====
// ih_cpu_model: behavioural cpu sequencer and handler timing.
// Assumes one clock; handler length comes from the bench via svc_len.
`timescale 1ns/100ps
`default_nettype none
module ih_cpu_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // from the interrupt block
  input  wire logic        irq_take_r,
  input  wire logic [15:0] handler_vector,
  // bench control and observation
  input  wire logic [7:0]  svc_len,
  output logic             rfi,
  output logic             exc_window,
  output logic [15:0]      entry_vector,
  output logic [7:0]       takes
);
  logic [7:0] left_r;
  logic [2:0] win_r;
  // entry loads the vector, handler runs svc_len cycles, then returns
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 8'h00;
      rfi <= 1'b0;
      takes <= 8'h00;
      entry_vector <= 16'h0000;
    end else begin
      rfi <= (left_r == 8'h01); // one-cycle return pulse
      if (irq_take_r) begin
        entry_vector <= handler_vector;
        takes <= takes + 8'h01;
        left_r <= svc_len; // svc_len of 0 would never return
      end else if (left_r != 8'h00) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
  // prefix-style non-interruptible cycle, one in eight, stresses latency
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      win_r <= 3'h0;
      exc_window <= 1'b0;
    end else begin
      win_r <= win_r + 3'h1;
      exc_window <= (win_r == 3'h7);
    end
  end
endmodule // ih_cpu_model
`default_nettype wire

// ==== ih_top_test.sv ====
// ih_top_test: self-checking bench for the interrupt hierarchy.
// Assumes ih_top, ih_cpu_model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ih_top_test;
  import ih_pkg::*;
  logic clock, rst_n, avs_read, avs_write, tmr1_flag, tmr1_en, supmon_flag;
  logic supmon_en, tmr2_flag, tmr2_en, tw3_flag, tw3_en, spis_en, spim_en;
  logic wdt_flag, wdt_en, stop_mode, exc_window, rfi, irq_req_r;
  logic irq_take_r, in_service_bit, avs_waitrequest;
  logic [1:0] avs_byteenable;
  logic [2:0] spis_flag;
  logic [3:0] avs_address, adc_flag, adc_en, spim_flag;
  logic [6:0] port6_flag, port6_en;
  logic [7:0] twm_flag, twm_en, svc_len, takes;
  logic [13:0] tws_flag, tws_en;
  logic [15:0] avs_writedata, cmp_lo_flag, cmp_lo_en, cmp_hi_flag, cmp_hi_en;
  logic [15:0] avs_readdata, handler_vector, entry_vector, rd;
  logic [23:0] pin012_flag, pin012_en;
  int miscompares, comparisons;
  ih_top ih_top_i (.*);
  ih_cpu_model ih_cpu_model_i (.*);
  always #20 clock = ~clock;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access; holds the request until waitrequest is seen low
  // a slave that never answers is caught by the watchdog, not here
  task bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rdchk(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rd, e);
  endtask
  task cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  task stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_reset;
    for (int a = 0; a < 10; a++) rdchk(a[3:0], IH_RST_ZERO);
    chk(handler_vector, IH_RST_VECT);
    bus(1'b1, IH_ADDR_ID1, 16'hffff);
    bus(1'b1, 4'h9, 16'hffff);
    rdchk(IH_ADDR_ID1, IH_RST_ZERO);
    rdchk(4'h9, 16'h0000);
  endtask
  task set_src(input int k, input logic f, input logic e);
    case (k)
      0: {tmr1_flag, tmr1_en} <= {f, e};
      1: {supmon_flag, supmon_en} <= {f, e};
      2: {tws_flag[13], tws_en[13]} <= {f, e};
      3: {tmr2_flag, tmr2_en} <= {f, e};
      4: {tw3_flag, tw3_en} <= {f, e};
      5: {spim_flag[3], spim_en} <= {f, e};
      default: {wdt_flag, wdt_en} <= {f, e};
    endcase
  endtask
  // each module and the system source, first without then with enable
  task t_modules;
    for (int k = 0; k < 7; k++) begin
      set_src(k, 1'b1, 1'b0);
      cycles(3);
      rdchk(IH_ADDR_PEND, 16'h0000);
      set_src(k, 1'b1, 1'b1);
      cycles(3);
      rdchk(IH_ADDR_PEND, (k == 6) ? 16'h8000 : 16'h0001 << k);
      chk({15'h0000, irq_req_r}, 16'h0000);
      set_src(k, 1'b0, 1'b0);
    end
    bus(1'b1, IH_ADDR_SWF, 16'h0004);
    rdchk(IH_ADDR_PEND, 16'h0008);
    bus(1'b1, IH_ADDR_SWF, 16'h0000);
  endtask
  task t_ids;
    {port6_flag, port6_en, supmon_flag, supmon_en} <= {7'h40, 7'h7f, 2'b11};
    {twm_flag, twm_en, adc_flag, adc_en} <= {8'h10, 8'h10, 4'h4, 4'h4};
    {tw3_flag, tw3_en, spis_flag, spis_en} <= {2'b11, 3'h2, 1'b1};
    {cmp_lo_flag, cmp_hi_flag, cmp_hi_en} <= {16'h0001, 16'h8000, 16'h8000};
    {spim_flag, spim_en} <= {4'h1, 1'b1};
    cycles(12);
    rdchk(IH_ADDR_ID1, 16'h01c0);
    rdchk(IH_ADDR_ID4, 16'h0007);
    rdchk(IH_ADDR_ID5, 16'h0003);
    {twm_en, adc_en, cmp_hi_en, cmp_lo_en} <= {8'h0f, 4'h0, 16'h0, 16'h1};
    cycles(3);
    rdchk(IH_ADDR_ID1, 16'h00c0);
    rdchk(IH_ADDR_ID4, 16'h0006);
    rdchk(IH_ADDR_ID5, 16'h0003);
    {port6_flag, supmon_flag, twm_flag, tw3_flag, spis_flag} <= '0;
    {cmp_lo_flag, cmp_hi_flag, spim_flag} <= '0;
    cycles(12);
  endtask
  // a two-cycle pin pulse is filtered, a held level gets through
  task t_glitch;
    {pin012_flag, pin012_en} <= {24'h800000, 24'h800000};
    cycles(2);
    pin012_flag <= 24'h000000;
    cycles(10);
    rdchk(IH_ADDR_PEND, 16'h0000);
    pin012_flag <= 24'h800000;
    cycles(10);
    rdchk(IH_ADDR_PEND, 16'h0001);
    pin012_flag <= 24'h000000;
    cycles(10);
    // in stop mode only the synchroniser delays a pin request
    {stop_mode, pin012_flag} <= {1'b1, 24'h800000};
    cycles(3);
    rdchk(IH_ADDR_PEND, 16'h0001);
    {stop_mode, pin012_flag} <= 25'h0000000;
    cycles(10);
  endtask
  task t_service(input logic [7:0] len);
    logic [7:0] t0;
    int n;
    svc_len <= len;
    bus(1'b1, IH_ADDR_VECT, 16'h5a3c);
    bus(1'b1, IH_ADDR_MASK, 16'h8001);
    bus(1'b1, IH_ADDR_CTRL, 16'h0001);
    {supmon_flag, supmon_en} <= 2'b11;
    t0 = takes;
    cycles(20);
    chk({8'h00, takes}, {8'h00, t0});
    bus(1'b1, IH_ADDR_CTRL, 16'h0000);
    bus(1'b1, IH_ADDR_MASK, 16'h0002);
    cycles(20);
    chk({8'h00, takes}, {8'h00, t0});
    bus(1'b1, IH_ADDR_CTRL, 16'h0001);
    n = 0;
    while (takes - t0 < 8'h02 && n < 300) begin
      cycles(1);
      n++;
    end
    chk({8'h00, takes - t0}, 16'h0002);
    chk(entry_vector, 16'h5a3c);
    chk({15'h0000, in_service_bit}, 16'h0001);
    supmon_flag <= 1'b0;
    cycles(len + 30);
    t0 = takes;
    cycles(30);
    chk({8'h00, takes}, {8'h00, t0});
    bus(1'b1, IH_ADDR_CTRL, 16'h0000);
    bus(1'b1, IH_ADDR_MASK, 16'h0000);
  endtask
  // reset in mid-run with state loaded, then a low-byte-only write
  task t_rerun;
    bus(1'b1, IH_ADDR_CTRL, 16'h0001);
    chk(handler_vector, 16'h5a3c);
    rst_n <= 1'b0;
    cycles(2);
    chk(handler_vector, IH_RST_VECT);
    rst_n <= 1'b1;
    rdchk(IH_ADDR_CTRL, IH_RST_ZERO);
    rdchk(IH_ADDR_VECT, IH_RST_VECT);
    avs_byteenable <= 2'b01;
    bus(1'b1, IH_ADDR_VECT, 16'hffff);
    avs_byteenable <= 2'b11;
    rdchk(IH_ADDR_VECT, 16'h00ff);
  endtask
  initial begin
    {avs_read, avs_write, tmr1_flag, tmr1_en, supmon_flag, supmon_en} = '0;
    {tmr2_flag, tmr2_en, tw3_flag, tw3_en, spis_en, spim_en} = '0;
    {wdt_flag, wdt_en, stop_mode, spis_flag, avs_address, adc_flag} = '0;
    {adc_en, spim_flag, port6_flag, port6_en, twm_flag, twm_en} = '0;
    {tws_flag, tws_en, avs_writedata, cmp_lo_flag, cmp_lo_en} = '0;
    {cmp_hi_flag, cmp_hi_en, pin012_flag, pin012_en} = '0;
    {clock, rst_n, svc_len, avs_byteenable} = {2'b00, 8'h04, 2'b11};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_modules;
    t_ids;
    t_glitch;
    t_service(8'h02);
    t_service(8'h14);
    t_rerun;
    stop_test;
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule // ih_top_test
`default_nettype wire
